// ### rtl/lrrx_buf_mem.sv
// eight-entry receive data buffer with registered read port
module lrrx_buf_mem (
  input wire logic sys_clk_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [2:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [0:7];

  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule : lrrx_buf_mem

// ### rtl/lrrx_pkg.sv
// package: register map, field positions, reset values and timing constants
package lrrx_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_BAUD_DIV = 8'h04;
  localparam logic [7:0] ADDR_FIRST_PRESCALER = 8'h08;
  localparam logic [7:0] ADDR_SECOND_PRESCALER = 8'h0c;
  localparam logic [7:0] ADDR_TRANSFER_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_RESPONSE_FORMAT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_ERROR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_TX_DATA = 8'h20;
  localparam logic [7:0] ADDR_DATA_BUF0 = 8'h40;
  localparam logic [7:0] ADDR_DATA_BUF_LAST = 8'h5c;
  // mode control fields
  localparam int MC_DIVSEL_BIT = 0;
  // prescaler fields
  localparam int BD_SUBCLK_LSB = 0;
  localparam int P0_DIV2_BIT = 8;
  localparam int P1_SEL_BIT = 8;
  // transfer control fields
  localparam int TC_START_BIT = 0;
  localparam int TC_TX_BIT = 1;
  // response format fields
  localparam int RF_LEN_LSB = 0;
  localparam int RF_DIR_BIT = 4;
  localparam int RF_CKMODEL_BIT = 5;
  // status fields
  localparam int ST_FRC_BIT = 0;
  localparam int ST_D1_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  // error status fields
  localparam int ES_BITERR_BIT = 0;
  localparam int ES_FER_BIT = 1;
  localparam int ES_CSE_BIT = 2;
  // subclock select codes
  localparam logic [1:0] SUBCLK_BASE = 2'h0;
  localparam logic [1:0] SUBCLK_DIV2 = 2'h1;
  localparam logic [1:0] SUBCLK_DIV8 = 2'h2;
  localparam logic [1:0] SUBCLK_TENK = 2'h3;
  // bit timing in lin clocks, response length limits
  localparam logic [3:0] BT8_LAST = 4'h7;
  localparam logic [3:0] BT16_LAST = 4'hf;
  localparam logic [3:0] BT8_CMP = 4'h4;
  localparam logic [3:0] BT16_CMP = 4'hc;
  localparam logic [3:0] BT8_HALF = 4'h3;
  localparam logic [3:0] BT16_HALF = 4'h7;
  localparam logic [3:0] LEN_MAX = 4'h8;
  localparam logic [3:0] LEN_FOUR = 4'h4;
  // reset values
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;
  localparam logic [7:0] SUBCLK_CNT_RST = 8'h00;
endpackage : lrrx_pkg

// ### rtl/lrrx_top.sv
// lin response receiver, baud prescaler chain and bit transmitter with readback
// Overview of operation
// - idle until start bit, flag first byte
// - receive length bytes then one checksum
// - framing error aborts reception, skips checksum
// - judge checksum, set completion or error
// - on end clear start bit, idle
// - lin clock from divider, 8/16 per bit
// - divisor select: 0 gives 8, 1 gives 16
// - base, divide-by-2, divide-by-8 subclocks
// - 10417 bps from divide-by-(m+1) chain
// - transmit one bit per bit time
// - readback mismatch sets bit error flag
// - compare at clock 5 or 13
// - start bit verified half bit later
// - bytes stored in order, length capped at eight
// - direction bit; checksum model bit is stored but unused
module lrrx_top (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_rx_input_i,
  output logic bus_tx_output_o
);
  typedef enum logic [2:0] {LRRX_IDLE, LRRX_HUNT, LRRX_VERIFY, LRRX_DATA, LRRX_STOP,
    LRRX_JUDGE, LRRX_DONE} lrrx_state_t;

  logic [31:0] mode_control_reg;
  logic [31:0] baud_div_reg;
  logic [31:0] first_prescaler_reg;
  logic [31:0] second_prescaler_reg;
  logic [31:0] transfer_control_reg;
  logic [31:0] response_format_reg;
  logic [31:0] status_reg;
  logic [31:0] error_status_reg;
  logic [7:0] tx_data;
  logic rx_s1, rx_s2, rx_prev;
  logic bit_time_divisor_sel;
  logic [3:0] bit_last, bit_half, bit_cmp;
  logic wr, rd;
  logic [7:0] p0_cnt, pm_cnt;
  logic p0_tick, p0_half, first_prescaler_out, pm_tick;
  logic [2:0] sub_cnt, tenk_cnt;
  logic lin_sys_clock;
  lrrx_state_t state;
  logic [3:0] clk_cnt;
  logic [2:0] bit_idx;
  logic [7:0] shreg;
  logic [3:0] byte_cnt;
  logic [7:0] sum;
  logic [8:0] sum_add;
  logic ev_d1, ev_frc, ev_err, ev_fer, ev_cse, ev_ber, rx_end;
  logic buf_wr;
  logic [7:0] buf_rd;
  logic [3:0] len;
  logic tx_busy;
  logic [3:0] tx_clk;
  logic [3:0] tx_bit;
  logic [9:0] tx_frame;
  logic seen_high;

  assign bit_time_divisor_sel = mode_control_reg[lrrx_pkg::MC_DIVSEL_BIT];
  assign bit_last = bit_time_divisor_sel ? lrrx_pkg::BT16_LAST : lrrx_pkg::BT8_LAST;
  assign bit_half = bit_time_divisor_sel ? lrrx_pkg::BT16_HALF : lrrx_pkg::BT8_HALF;
  assign bit_cmp = bit_time_divisor_sel ? lrrx_pkg::BT16_CMP : lrrx_pkg::BT8_CMP;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign len = (response_format_reg[lrrx_pkg::RF_LEN_LSB +: 4] > lrrx_pkg::LEN_MAX) ?
    lrrx_pkg::LEN_MAX : response_format_reg[lrrx_pkg::RF_LEN_LSB +: 4];

  // two-flop synchroniser for the bus input
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= bus_rx_input_i;
      rx_s2 <= rx_s1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      p0_cnt <= lrrx_pkg::SUBCLK_CNT_RST;
      p0_half <= 1'b0;
    end else if (p0_cnt >= first_prescaler_reg[7:0]) begin
      p0_cnt <= lrrx_pkg::SUBCLK_CNT_RST;
      p0_half <= !p0_half;
    end else begin
      p0_cnt <= p0_cnt + 8'h01;
    end
  end
  assign p0_tick = (p0_cnt >= first_prescaler_reg[7:0]);
  assign first_prescaler_out = p0_tick &&
    (!first_prescaler_reg[lrrx_pkg::P0_DIV2_BIT] || p0_half);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sub_cnt <= 3'h0;
    end else if (first_prescaler_out) begin
      sub_cnt <= sub_cnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pm_cnt <= lrrx_pkg::SUBCLK_CNT_RST;
      tenk_cnt <= 3'h0;
    end else if (pm_cnt >= second_prescaler_reg[7:0]) begin
      pm_cnt <= lrrx_pkg::SUBCLK_CNT_RST;
      tenk_cnt <= tenk_cnt + 3'h1;
    end else begin
      pm_cnt <= pm_cnt + 8'h01;
    end
  end
  assign pm_tick = (pm_cnt >= second_prescaler_reg[7:0]) &&
    (second_prescaler_reg[lrrx_pkg::P1_SEL_BIT] ? (tenk_cnt[0] == 1'b1) :
    (tenk_cnt == 3'h7));

  always_comb begin
    case (baud_div_reg[lrrx_pkg::BD_SUBCLK_LSB +: 2])
      lrrx_pkg::SUBCLK_BASE: lin_sys_clock = first_prescaler_out;
      lrrx_pkg::SUBCLK_DIV2: lin_sys_clock = first_prescaler_out && sub_cnt[0];
      lrrx_pkg::SUBCLK_DIV8: lin_sys_clock = first_prescaler_out && (sub_cnt == 3'h7);
      lrrx_pkg::SUBCLK_TENK: lin_sys_clock = pm_tick;
      default: lin_sys_clock = 1'b0;
    endcase
  end

  assign sum_add = {1'b0, sum} + {1'b0, shreg};
  assign buf_wr = (state == LRRX_STOP) && lin_sys_clock && (clk_cnt == bit_half) &&
    rx_s2 && (byte_cnt < len) && (byte_cnt < lrrx_pkg::LEN_MAX);

  // receive sequencer
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state <= LRRX_IDLE;
      clk_cnt <= 4'h0;
      bit_idx <= 3'h0;
      shreg <= 8'h00;
      byte_cnt <= 4'h0;
      sum <= 8'h00;
      rx_prev <= 1'b1;
      seen_high <= 1'b0;
      ev_d1 <= 1'b0;
      ev_frc <= 1'b0;
      ev_fer <= 1'b0;
      ev_cse <= 1'b0;
      rx_end <= 1'b0;
    end else begin
      ev_d1 <= 1'b0;
      ev_frc <= 1'b0;
      ev_fer <= 1'b0;
      ev_cse <= 1'b0;
      rx_end <= 1'b0;
      if (lin_sys_clock) begin
        rx_prev <= rx_s2;
        if (rx_s2) begin
          seen_high <= 1'b1;
        end
      end
      case (state)
        LRRX_IDLE: begin
          // start bit still set in the cycle after done, so ignore it then
          if (!rx_end && transfer_control_reg[lrrx_pkg::TC_START_BIT] &&
              !response_format_reg[lrrx_pkg::RF_DIR_BIT]) begin
            state <= LRRX_HUNT;
            byte_cnt <= 4'h0;
            sum <= 8'h00;
          end
        end
        LRRX_HUNT: begin
          if (lin_sys_clock && seen_high && rx_prev && !rx_s2) begin
            state <= LRRX_VERIFY;
            clk_cnt <= 4'h1;
          end
        end
        LRRX_VERIFY: begin
          if (lin_sys_clock) begin
            clk_cnt <= clk_cnt + 4'h1;
            if (clk_cnt == bit_half) begin
              clk_cnt <= 4'h0;
              bit_idx <= 3'h0;
              state <= rx_s2 ? LRRX_HUNT : LRRX_DATA;
            end
          end
        end
        LRRX_DATA: begin
          if (lin_sys_clock) begin
            clk_cnt <= clk_cnt + 4'h1;
            if (clk_cnt == bit_last) begin
              clk_cnt <= 4'h0;
              shreg <= {rx_s2, shreg[7:1]};
              bit_idx <= bit_idx + 3'h1;
              if (bit_idx == 3'h7) begin
                state <= LRRX_STOP;
              end
            end
          end
        end
        LRRX_STOP: begin
          if (lin_sys_clock) begin
            clk_cnt <= clk_cnt + 4'h1;
            if (clk_cnt == bit_last) begin
              clk_cnt <= 4'h0;
              if (!rx_s2) begin
                ev_fer <= 1'b1;
                state <= LRRX_DONE;
              end else if (byte_cnt < len) begin
                byte_cnt <= byte_cnt + 4'h1;
                sum <= sum_add[7:0] + {7'h00, sum_add[8]};
                ev_d1 <= (byte_cnt == 4'h0);
                state <= LRRX_HUNT;
              end else begin
                state <= LRRX_JUDGE;
              end
            end
          end
        end
        LRRX_JUDGE: begin
          // sum plus checksum is ff
          if ((sum_add[7:0] + {7'h00, sum_add[8]}) == 8'hff) begin
            ev_frc <= 1'b1;
          end else begin
            ev_cse <= 1'b1;
          end
          state <= LRRX_DONE;
        end
        LRRX_DONE: begin
          rx_end <= 1'b1;
          state <= LRRX_IDLE;
        end
        default: state <= LRRX_IDLE;
      endcase
    end
  end

  lrrx_buf_mem u_buf (
    .sys_clk_i(sys_clk_i),
    .wr_en_i(buf_wr),
    .wr_addr_i(byte_cnt[2:0]),
    .wr_data_i(shreg),
    .rd_addr_i(paddr[4:2]),
    .rd_data_o(buf_rd)
  );

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tx_busy <= 1'b0;
      tx_clk <= 4'h0;
      tx_bit <= 4'h0;
      tx_frame <= 10'h3ff;
      bus_tx_output_o <= 1'b1;
      ev_ber <= 1'b0;
    end else begin
      ev_ber <= 1'b0;
      if (!tx_busy) begin
        bus_tx_output_o <= 1'b1;
        if (wr && (paddr == lrrx_pkg::ADDR_TX_DATA) &&
            response_format_reg[lrrx_pkg::RF_DIR_BIT]) begin
          tx_busy <= 1'b1;
          tx_frame <= {1'b1, pwdata[7:0], 1'b0};
          tx_clk <= 4'h0;
          tx_bit <= 4'h0;
        end
      end else if (lin_sys_clock) begin
        bus_tx_output_o <= tx_frame[0];
        tx_clk <= tx_clk + 4'h1;
        // readback at clock 5 or 13
        if (tx_clk == bit_cmp) begin
          ev_ber <= (rx_s2 != bus_tx_output_o);
        end
        if (tx_clk == bit_last) begin
          tx_clk <= 4'h0;
          tx_frame <= {1'b1, tx_frame[9:1]};
          tx_bit <= tx_bit + 4'h1;
          if (tx_bit == 4'h9) begin
            tx_busy <= 1'b0;
          end
        end
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_control_reg <= 32'h0;
      baud_div_reg <= 32'h0;
      first_prescaler_reg <= 32'h0;
      second_prescaler_reg <= 32'h0;
      response_format_reg <= 32'h0;
      tx_data <= 8'h00;
    end else if (wr) begin
      case (paddr)
        lrrx_pkg::ADDR_MODE_CONTROL: mode_control_reg <= {31'h0, pwdata[0]};
        lrrx_pkg::ADDR_BAUD_DIV: baud_div_reg <= {30'h0, pwdata[1:0]};
        lrrx_pkg::ADDR_FIRST_PRESCALER: first_prescaler_reg <= {23'h0, pwdata[8:0]};
        lrrx_pkg::ADDR_SECOND_PRESCALER: second_prescaler_reg <= {23'h0, pwdata[8:0]};
        lrrx_pkg::ADDR_RESPONSE_FORMAT: response_format_reg <= {26'h0, pwdata[5:0]};
        lrrx_pkg::ADDR_TX_DATA: tx_data <= pwdata[7:0];
        default: tx_data <= tx_data;
      endcase
    end
  end

  // transfer control: hardware clear at end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      transfer_control_reg <= 32'h0;
    end else if (rx_end) begin
      transfer_control_reg <= 32'h0;
    end else if (wr && (paddr == lrrx_pkg::ADDR_TRANSFER_CONTROL)) begin
      transfer_control_reg <= {31'h0, pwdata[lrrx_pkg::TC_START_BIT]};
    end
  end

  localparam int ST_IDX_FRC = lrrx_pkg::ST_FRC_BIT;
  localparam int ST_IDX_D1 = lrrx_pkg::ST_D1_BIT;
  localparam int ST_IDX_ERR = lrrx_pkg::ST_ERR_BIT;
  localparam int ES_IDX_BITERR = lrrx_pkg::ES_BITERR_BIT;
  localparam int ES_IDX_FER = lrrx_pkg::ES_FER_BIT;
  localparam int ES_IDX_CSE = lrrx_pkg::ES_CSE_BIT;

  // sticky status, software writes zero to clear, set wins
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      status_reg <= 32'h0;
      error_status_reg <= 32'h0;
    end else begin
      status_reg[31:3] <= 29'h0;
      error_status_reg[31:3] <= 29'h0;
      status_reg[ST_IDX_FRC] <= ev_frc || (status_reg[ST_IDX_FRC] &&
        !(wr && paddr == lrrx_pkg::ADDR_STATUS && !pwdata[ST_IDX_FRC]));
      status_reg[ST_IDX_D1] <= ev_d1 || (status_reg[ST_IDX_D1] &&
        !(wr && paddr == lrrx_pkg::ADDR_STATUS && !pwdata[ST_IDX_D1]));
      status_reg[ST_IDX_ERR] <= ev_fer || ev_cse || ev_ber || (status_reg[ST_IDX_ERR] &&
        !(wr && paddr == lrrx_pkg::ADDR_STATUS && !pwdata[ST_IDX_ERR]));
      error_status_reg[ES_IDX_BITERR] <= ev_ber || (error_status_reg[ES_IDX_BITERR] &&
        !(wr && paddr == lrrx_pkg::ADDR_ERROR_STATUS && !pwdata[ES_IDX_BITERR]));
      error_status_reg[ES_IDX_FER] <= ev_fer || (error_status_reg[ES_IDX_FER] &&
        !(wr && paddr == lrrx_pkg::ADDR_ERROR_STATUS && !pwdata[ES_IDX_FER]));
      error_status_reg[ES_IDX_CSE] <= ev_cse || (error_status_reg[ES_IDX_CSE] &&
        !(wr && paddr == lrrx_pkg::ADDR_ERROR_STATUS && !pwdata[ES_IDX_CSE]));
    end
  end

  // apb: buffer reads need one wait cycle for the registered memory
  logic rd_wait;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= psel && !penable;
    end
  end
  assign pready = !(rd && paddr >= lrrx_pkg::ADDR_DATA_BUF0 &&
    paddr <= lrrx_pkg::ADDR_DATA_BUF_LAST && rd_wait);

  always_comb begin
    pslverr = 1'b0;
    case (paddr)
      lrrx_pkg::ADDR_MODE_CONTROL: prdata = mode_control_reg;
      lrrx_pkg::ADDR_BAUD_DIV: prdata = baud_div_reg;
      lrrx_pkg::ADDR_FIRST_PRESCALER: prdata = first_prescaler_reg;
      lrrx_pkg::ADDR_SECOND_PRESCALER: prdata = second_prescaler_reg;
      lrrx_pkg::ADDR_TRANSFER_CONTROL: prdata = transfer_control_reg;
      lrrx_pkg::ADDR_RESPONSE_FORMAT: prdata = response_format_reg;
      lrrx_pkg::ADDR_STATUS: prdata = status_reg;
      lrrx_pkg::ADDR_ERROR_STATUS: prdata = error_status_reg;
      lrrx_pkg::ADDR_TX_DATA: prdata = {24'h0, tx_data};
      default: begin
        if (paddr >= lrrx_pkg::ADDR_DATA_BUF0 && paddr <= lrrx_pkg::ADDR_DATA_BUF_LAST &&
            paddr[1:0] == 2'h0) begin
          prdata = {24'h0, buf_rd};
        end else begin
          prdata = 32'h0;
          pslverr = psel && penable;
        end
      end
    endcase
  end
endmodule : lrrx_top

// ### tb/lrrx_chk.sv
// checker: apb answer timing and transmit line assertions for the lin block
module lrrx_chk (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_rx_input_i,
  input wire logic bus_tx_output_o
);
  logic buf_a;
  logic map_a;
  logic acc;
  assign buf_a = paddr >= lrrx_pkg::ADDR_DATA_BUF0 && paddr <= lrrx_pkg::ADDR_DATA_BUF_LAST;
  assign map_a = (buf_a || paddr <= lrrx_pkg::ADDR_TX_DATA) && paddr[1:0] == 2'h0;
  assign acc = psel && penable;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  property p_err_map;
    acc && !map_a |-> pslverr;
  endproperty
  a_err_map: assert property (p_err_map) else $error("no slave error on unmapped access");
  property p_err_only;
    pslverr |-> acc && !map_a;
  endproperty
  a_err_only: assert property (p_err_only) else $error("slave error out of place");
  property p_unmap_rd;
    acc && !pwrite && !map_a |-> prdata == 32'h0;
  endproperty
  a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read not zero");
  property p_reg_wait;
    acc && (pwrite || !buf_a) |-> pready;
  endproperty
  a_reg_wait: assert property (p_reg_wait) else $error("register access stalled");
  property p_buf_wait;
    psel && !penable && !pwrite && buf_a ##1 acc |-> !pready ##1 pready;
  endproperty
  a_buf_wait: assert property (p_buf_wait) else $error("buffer read wait wrong");
  property p_bit_min;
    $changed(bus_tx_output_o) |=> $stable(bus_tx_output_o) [*7];
  endproperty
  a_bit_min: assert property (p_bit_min) else $error("transmit bit shorter than 8 clocks");
  property p_st_hi;
    acc && !pwrite && paddr == lrrx_pkg::ADDR_STATUS |-> prdata[31:3] == 29'h0;
  endproperty
  a_st_hi: assert property (p_st_hi) else $error("status upper bits set");
  property p_rst_idle;
    disable iff (1'b0) $fell(sys_rst_i) |-> bus_tx_output_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("transmit line not idle after reset");
  c_buf: cover property (psel && !penable && !pwrite && buf_a);
  c_err: cover property (pslverr);
  c_tx: cover property ($fell(bus_tx_output_o));
endmodule : lrrx_chk
bind lrrx_top lrrx_chk chk_u (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .bus_rx_input_i(bus_rx_input_i),
  .bus_tx_output_o(bus_tx_output_o)
);

// ### tb/lrrx_lin_node.sv
// lin bus node model: transceiver readback path and a byte sender
module lrrx_lin_node (
  input wire logic sys_clk_i,
  input wire logic tx_i,
  output logic rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'b1;
  logic stuck = 1'b0;
  // wired-and bus with pull-up, stuck models a shorted line
  assign rx_o = tx_i & drv & !stuck;
  task automatic pulse(input int n);
    @(posedge sys_clk_i);
    drv <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    drv <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
  endtask : pulse
  task automatic send(input logic [7:0] d, input logic stop_ok, input int bitc);
    logic [9:0] fr;
    fr = {stop_ok, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk_i);
      drv <= fr[i];
      repeat (bitc - 1) @(posedge sys_clk_i);
    end
    @(posedge sys_clk_i);
    drv <= 1'b1;
    repeat (bitc) @(posedge sys_clk_i);
  endtask : send
endmodule : lrrx_lin_node

// ### tb/tb.sv
// testbench: response reception, bit timing and readback over apb
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx;
  logic tx;
  logic [31:0] rd;
  logic serr;
  int errors = 0;
  int compares = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  lrrx_top dut_u (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus_rx_input_i(rx),
    .bus_tx_output_o(tx)
  );
  lrrx_lin_node node_u (.sys_clk_i(sys_clk_i), .tx_i(tx), .rx_o(rx));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cfg(input logic b, input logic [1:0] s, input logic [31:0] m);
    apb(1'b1, lrrx_pkg::ADDR_MODE_CONTROL, {31'h0, b});
    // subclock taken from the caller, independent of the divisor
    apb(1'b1, lrrx_pkg::ADDR_BAUD_DIV, {30'h0, s});
    apb(1'b1, lrrx_pkg::ADDR_FIRST_PRESCALER, 32'h1);
    apb(1'b1, lrrx_pkg::ADDR_SECOND_PRESCALER, m);
  endtask : cfg
  task automatic t_regs();
    apb(1'b0, lrrx_pkg::ADDR_STATUS, 32'h0);
    chk("status rst", rd, 32'h0);
    apb(1'b0, lrrx_pkg::ADDR_TRANSFER_CONTROL, 32'h0);
    chk("tc rst", rd, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", {31'h0, serr}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask : t_regs
  task automatic t_rx(input logic [7:0] b0, input logic [7:0] b1, input logic ok, input logic fe);
    logic [8:0] s;
    logic [7:0] cs;
    int n;
    s = {1'b0, b0} + {1'b0, b1};
    cs = ~(s[7:0] + {7'h0, s[8]}) ^ {7'h0, !ok};
    n = 0;
    cfg(1'b0, lrrx_pkg::SUBCLK_BASE, 32'h1);
    apb(1'b1, lrrx_pkg::ADDR_RESPONSE_FORMAT, 32'h2);
    apb(1'b1, lrrx_pkg::ADDR_TRANSFER_CONTROL, 32'h1);
    node_u.pulse(3);
    node_u.send(b0, !fe, 16);
    if (!fe) begin
      node_u.send(b1, 1'b1, 16);
      node_u.send(cs, 1'b1, 16);
    end
    do begin
      apb(1'b0, lrrx_pkg::ADDR_TRANSFER_CONTROL, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    chk("tc end", rd & 32'h1, 32'h0);
    apb(1'b0, lrrx_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd & (fe ? 32'h5 : 32'h7), fe ? 32'h4 : (ok ? 32'h3 : 32'h6));
    apb(1'b0, lrrx_pkg::ADDR_ERROR_STATUS, 32'h0);
    chk("errstat", rd, fe ? 32'h2 : (ok ? 32'h0 : 32'h4));
    if (!fe) begin
      apb(1'b0, lrrx_pkg::ADDR_DATA_BUF0, 32'h0);
      chk("buf0", rd, {24'h0, b0});
      apb(1'b0, lrrx_pkg::ADDR_DATA_BUF0 + 8'h04, 32'h0);
      chk("buf1", rd, {24'h0, b1});
    end
    apb(1'b1, lrrx_pkg::ADDR_STATUS, 32'h0);
    apb(1'b1, lrrx_pkg::ADDR_ERROR_STATUS, 32'h0);
    apb(1'b0, lrrx_pkg::ADDR_STATUS, 32'h0);
    chk("status clr", rd, 32'h0);
  endtask : t_rx
  task automatic t_tx();
    logic [1:0] sc[6] = '{lrrx_pkg::SUBCLK_BASE, lrrx_pkg::SUBCLK_BASE, lrrx_pkg::SUBCLK_DIV2,
                          lrrx_pkg::SUBCLK_DIV8, lrrx_pkg::SUBCLK_TENK, lrrx_pkg::SUBCLK_TENK};
    int bt[6] = '{16, 32, 32, 128, 128, 64};
    int c;
    for (int i = 0; i < 6; i++) begin
      // last entry takes the divide-by-2 branch with sixteen clocks a bit
      cfg(i == 1 || i == 5, sc[i], (i == 5) ? 32'h101 : 32'h1);
      apb(1'b1, lrrx_pkg::ADDR_RESPONSE_FORMAT, 32'h10);
      apb(1'b1, lrrx_pkg::ADDR_TX_DATA, 32'h0);
      c = 0;
      while (tx !== 1'b0 && c < 400) begin
        @(negedge sys_clk_i);
        c++;
      end
      c = 0;
      while (tx === 1'b0 && c < 2000) begin
        @(negedge sys_clk_i);
        c++;
      end
      chk("low span", 32'(c), 32'(9 * bt[i]));
      repeat (2 * bt[i]) @(posedge sys_clk_i);
    end
    apb(1'b0, lrrx_pkg::ADDR_ERROR_STATUS, 32'h0);
    chk("no bit error", rd & 32'h1, 32'h0);
    cfg(1'b0, lrrx_pkg::SUBCLK_BASE, 32'h1);
    node_u.stuck <= 1'b1;
    apb(1'b1, lrrx_pkg::ADDR_TX_DATA, 32'hff);
    repeat (200) @(posedge sys_clk_i);
    node_u.stuck <= 1'b0;
    apb(1'b0, lrrx_pkg::ADDR_ERROR_STATUS, 32'h0);
    chk("bit error", rd & 32'h1, 32'h1);
  endtask : t_tx
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    errors++;
    results();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_rx(8'ha5, 8'hc3, 1'b1, 1'b0);
    t_rx(8'h81, 8'hff, 1'b0, 1'b0);
    t_rx(8'h3c, 8'h00, 1'b1, 1'b1);
    t_tx();
    results();
  end
endmodule : tb
